// ---- sas_pkg.sv ----
// package of constants and types for the successive-approximation converter sequencer
package sas_pkg;

	// register bus
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam logic [7:0]  RESULT_INDEX    = 8'h0a;
	localparam logic [7:0]  CTRL_INDEX      = 8'h0b;
	localparam logic [7:0]  IRQ_STAT_INDEX  = 8'h0c;
	localparam logic [7:0]  IRQ_MASK_INDEX  = 8'h0d;

	// control/status fields
	localparam int          DONE_BIT        = 7;
	localparam int          ON_BIT          = 5;
	localparam int          CHAN_LSB        = 0;
	localparam int          CHAN_W          = 4;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  RESULT_RESET    = 8'h00;
	localparam logic [7:0]  FULL_SCALE      = 8'hff;
	localparam logic [7:0]  ZERO_SCALE      = 8'h00;
	localparam int          NUM_CHANNELS    = 12;
	localparam logic [3:0]  LAST_CHANNEL    = 4'hb;

	// interrupt status bits
	localparam int          EV_DONE_BIT     = 0;
	localparam int          EV_ABORT_BIT    = 1;
	localparam logic [1:0]  IRQ_RESET       = 2'h0;

	// timing
	localparam int          CPU_CLK_MHZ     = 250;
	localparam int          CLK_DIV         = 4;
	localparam int          CONV_PERIODS    = 12;
	localparam int          SAR_STEPS       = 8;
	localparam int          LOAD_PERIODS    = CONV_PERIODS - SAR_STEPS;
	localparam logic [1:0]  DIV_LAST        = 2'(CLK_DIV - 1);
	localparam logic [3:0]  LOAD_LAST       = 4'(LOAD_PERIODS - 1);
	localparam logic [3:0]  SAR_LAST        = 4'(SAR_STEPS - 1);

	typedef enum {
		SAS_OFF,
		SAS_LOAD,
		SAS_CONV
	} sas_state_t;

	// register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} sas_bus_req_t;

	// analog front-end controls
	typedef struct packed {
		logic              powerOn;
		logic              sampleConnect;
		logic [CHAN_W-1:0] channel;
		logic [7:0]        dacCode;
	} sas_afe_t;

endpackage

// ---- sas_adc_sequencer.sv ----
// control logic of the successive-approximation converter with its register port
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////////
module sas_adc_sequencer
	import sas_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// register port
	input  wire sas_bus_req_t      busReq,
	output var  logic [DATA_W-1:0] rdData_ff,
	// processor low-power modes
	input  wire logic              waitMode,
	input  wire logic              haltMode,
	// analog front end
	input  wire logic              cmpHigh,
	output var  sas_afe_t          afe_ff,
	// interrupt
	output var  logic              irq_ff
);

	//////////////////////////////////////////////////////////////////////////////////////
	// declarations

	sas_state_t        state_ff;
	sas_state_t        nxt_state;
	logic [1:0]        divCnt_ff;
	logic              tick;
	logic [3:0]        phaseCnt_ff;
	logic [7:0]        sar_ff;
	logic [7:0]        nxt_sar;
	logic [7:0]        result_ff;
	logic              done_ff;
	logic              on_ff;
	logic [CHAN_W-1:0] chan_ff;
	logic [1:0]        irqStat_ff;
	logic [1:0]        irqMask_ff;
	logic              ctrlWr;
	logic              resultRd;
	logic              statRd;
	logic              active;
	logic              lastStep;
	logic              aborted;
	logic              convEntry;
	logic              maskWr;

	// register index compare, used by every strobe decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == idx;
	endfunction

	assign ctrlWr   = busReq.wr && hit(busReq.addr, CTRL_INDEX);
	assign resultRd = busReq.rd && hit(busReq.addr, RESULT_INDEX);
	assign statRd   = busReq.rd && hit(busReq.addr, IRQ_STAT_INDEX);
	// wait mode is deliberately not looked at: the converter keeps running in it
	assign active   = on_ff && !haltMode;
	assign lastStep = tick && state_ff == SAS_CONV && phaseCnt_ff == SAR_LAST;
	// a control write while running drops the conversion in flight
	assign aborted  = ctrlWr && on_ff && state_ff != SAS_OFF;
	// last cycle of the load phase: the msb trial is loaded here for the first step
	assign convEntry = nxt_state == SAS_CONV && state_ff != SAS_CONV;
	assign maskWr    = busReq.wr && hit(busReq.addr, IRQ_MASK_INDEX);

	//////////////////////////////////////////////////////////////////////////////////////
	// converter clock enable

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !active || ctrlWr) begin
			divCnt_ff <= 2'h0;
		end else if (divCnt_ff == DIV_LAST) begin
			divCnt_ff <= 2'h0;
		end else begin
			divCnt_ff <= divCnt_ff + 2'h1;
		end
	end

	assign tick = active && divCnt_ff == DIV_LAST;

	//////////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SAS_OFF: begin
				if (active) begin
					nxt_state = SAS_LOAD;
				end
			end
			SAS_LOAD: begin
				if (tick && phaseCnt_ff == LOAD_LAST) begin
					nxt_state = SAS_CONV;
				end
			end
			SAS_CONV: begin
				if (lastStep) begin
					nxt_state = SAS_LOAD;
				end
			end
			default: begin
				nxt_state = SAS_OFF;
			end
		endcase
		if (!active) begin
			nxt_state = SAS_OFF;
		end else if (ctrlWr) begin
			nxt_state = SAS_LOAD;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= SAS_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// phase counter: four load periods plus eight steps make twelve converter clocks
	always_ff @(posedge ref_clk) begin
		if (!rst_n || nxt_state != state_ff || ctrlWr) begin
			phaseCnt_ff <= 4'h0;
		end else if (tick) begin
			phaseCnt_ff <= phaseCnt_ff + 4'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// successive approximation

	// trial bit for the next step is set; comparator keeps or drops the current one
	always_comb begin
		nxt_sar = sar_ff;
		if (state_ff == SAS_CONV && tick) begin
			nxt_sar[3'(SAR_LAST - phaseCnt_ff)] = cmpHigh;
			if (phaseCnt_ff != SAR_LAST) begin
				nxt_sar[3'(SAR_LAST - phaseCnt_ff - 4'h1)] = 1'b1;
			end
		end
	end

	// an input above the top keeps every trial bit, giving ffh; below the bottom, 00h
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sar_ff <= ZERO_SCALE;
		end else if (convEntry) begin
			sar_ff <= 8'h80;
		end else begin
			sar_ff <= nxt_sar;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// result and control/status registers

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			result_ff <= RESULT_RESET;
		end else if (lastStep && !ctrlWr) begin
			result_ff <= nxt_sar;
		end
	end

	// reserved bits 6 and 4 are not stored, so they always read back as zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			on_ff <= CTRL_RESET[ON_BIT];
		end else if (ctrlWr) begin
			on_ff <= busReq.wdata[ON_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			chan_ff <= CTRL_RESET[CHAN_LSB +: CHAN_W];
		end else if (ctrlWr) begin
			chan_ff <= busReq.wdata[CHAN_LSB +: CHAN_W];
		end
	end

	// a completion in the same cycle as a result read wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			done_ff <= CTRL_RESET[DONE_BIT];
		end else if (ctrlWr) begin
			done_ff <= 1'b0;
		end else if (lastStep) begin
			done_ff <= 1'b1;
		end else if (resultRd) begin
			done_ff <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// sticky event status, mask and system interrupt line

	// an event in the cycle of a status read wins, so no event is ever lost
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irqStat_ff <= IRQ_RESET;
		end else begin
			if (lastStep && !ctrlWr) begin
				irqStat_ff[EV_DONE_BIT] <= 1'b1;
			end else if (statRd) begin
				irqStat_ff[EV_DONE_BIT] <= 1'b0;
			end
			if (aborted) begin
				irqStat_ff[EV_ABORT_BIT] <= 1'b1;
			end else if (statRd) begin
				irqStat_ff[EV_ABORT_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irqMask_ff <= IRQ_RESET;
		end else if (maskWr) begin
			irqMask_ff <= busReq.wdata[1:0];
		end
	end

	// separate system line, raised by any status event whose mask bit is set; masked off at reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irqStat_ff & irqMask_ff);
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdData_ff <= '0;
		end else if (busReq.rd) begin
			case (busReq.addr)
				RESULT_INDEX: begin
					rdData_ff <= result_ff;
				end
				CTRL_INDEX: begin
					rdData_ff <= {done_ff, 1'b0, on_ff, 1'b0, chan_ff};
				end
				IRQ_STAT_INDEX: begin
					rdData_ff <= {6'h00, irqStat_ff};
				end
				IRQ_MASK_INDEX: begin
					rdData_ff <= {6'h00, irqMask_ff};
				end
				default: begin
					// unmapped indexes answer zero rather than floating data
					rdData_ff <= 8'h00;
				end
			endcase
		end else begin
			rdData_ff <= 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// analog front end drive

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			afe_ff <= '0;
		end else begin
			afe_ff.powerOn       <= active;
			afe_ff.sampleConnect <= nxt_state == SAS_LOAD;
			// codes past the last input clamp, so no unused input is ever switched in
			if (chan_ff > LAST_CHANNEL) begin
				afe_ff.channel <= LAST_CHANNEL;
			end else begin
				afe_ff.channel <= chan_ff;
			end
			// the trial code takes the register's next value, so the comparator sees it in the same cycle as the register
			if (convEntry) begin
				afe_ff.dacCode <= 8'h80;
			end else begin
				afe_ff.dacCode <= nxt_sar;
			end
		end
	end

endmodule

`default_nettype wire

// ---- sas_adc_sequencer_checker.sv ----
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_chk
	import sas_pkg::*;
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_n,
	// register port
	input wire sas_bus_req_t      busReq,
	input wire logic [DATA_W-1:0] rdData_ff,
	// modes, front end and interrupt
	input wire logic              waitMode,
	input wire logic              haltMode,
	input wire logic              cmpHigh,
	input wire sas_afe_t          afe_ff,
	input wire logic              irq_ff
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic       ctrlWr;
	logic [5:0] lowCnt_ff;
	logic       wrSeen_ff;
	logic [1:0] mask_ff;
	assign ctrlWr = busReq.wr && busReq.addr == CTRL_INDEX;
	always_ff @(posedge ref_clk) begin
		if (!rst_n || afe_ff.sampleConnect) lowCnt_ff <= 6'h00;
		else if (lowCnt_ff != 6'h3f) lowCnt_ff <= lowCnt_ff + 6'h01;
	end
	// a write, halt or power-down spoils the next phase length, so skip that one
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ctrlWr || haltMode || !afe_ff.powerOn) wrSeen_ff <= 1'b1;
		else if (!afe_ff.sampleConnect && lowCnt_ff == 6'h00) wrSeen_ff <= 1'b0;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) mask_ff <= 2'h0;
		else if (busReq.wr && busReq.addr == IRQ_MASK_INDEX) mask_ff <= busReq.wdata[1:0];
	end
	a_idle_rdata: assert property (!$past(busReq.rd) |-> rdData_ff == 8'h00)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (busReq.rd && (busReq.addr < RESULT_INDEX || busReq.addr > IRQ_MASK_INDEX)
		|=> rdData_ff == 8'h00) else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (busReq.rd && busReq.addr == CTRL_INDEX |=>
		rdData_ff[6] == 1'b0 && rdData_ff[4] == 1'b0) else $error("reserved control bits read high");
	a_halt_off: assert property (haltMode |=> !afe_ff.powerOn)
		else $error("converter powered while halted");
	a_off_write: assert property (ctrlWr && !busReq.wdata[ON_BIT] |-> ##2 !afe_ff.powerOn)
		else $error("converter still powered after off write");
	a_chan_select: assert property (ctrlWr |-> ##2 afe_ff.channel ==
		(($past(busReq.wdata[3:0], 2) > LAST_CHANNEL) ? LAST_CHANNEL : $past(busReq.wdata[3:0], 2)))
		else $error("wrong analog input selected");
	a_conv_len: assert property ($rose(afe_ff.sampleConnect) && !wrSeen_ff |-> lowCnt_ff == 6'd32)
		else $error("approximation phase not eight converter clocks");
	a_dac_start: assert property ($fell(afe_ff.sampleConnect) && afe_ff.powerOn |->
		##[0:3] afe_ff.dacCode == 8'h80) else $error("first trial code not msb");
	a_irq_masked: assert property ((mask_ff == 2'h0) [*3] |-> !irq_ff)
		else $error("interrupt high while fully masked");
	c_power: cover property ($rose(afe_ff.powerOn));
	c_phase: cover property ($rose(afe_ff.sampleConnect) && !wrSeen_ff);
	c_irq: cover property ($rose(irq_ff));
endmodule
bind sas_adc_sequencer sas_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .rdData_ff(rdData_ff),
	.waitMode(waitMode), .haltMode(haltMode), .cmpHigh(cmpHigh), .afe_ff(afe_ff), .irq_ff(irq_ff));
`default_nettype wire

// ---- sas_afe_model.sv ----
// sample-hold and comparator model of the analog inputs
`timescale 1ns/1ps
`default_nettype none
module sas_afe_model
	import sas_pkg::*;
(
	// clock
	input wire logic                         ref_clk,
	// front end controls and pin levels
	input wire sas_afe_t                     afe_ff,
	input wire logic [NUM_CHANNELS-1:0][7:0] level,
	// comparator
	output var logic                         cmpHigh
);
	logic [7:0] held_ff = 8'h00;
	logic       toggle_ff = 1'b0;
	always_ff @(posedge ref_clk) begin
		toggle_ff <= !toggle_ff;
		// cap keeps its charge once disconnected
		if (afe_ff.sampleConnect) held_ff <= level[afe_ff.channel];
	end
	// an unpowered comparator says nothing useful, so it wanders
	assign cmpHigh = afe_ff.powerOn ? (held_ff >= afe_ff.dacCode) : toggle_ff;
endmodule
`default_nettype wire

// ---- test_sar_adc_sequencer.sv ----
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_sequencer
	import sas_pkg::*;
;
	logic                         ref_clk, rst_n, waitMode, haltMode, cmpHigh, irq_ff;
	sas_bus_req_t                 busReq;
	logic [DATA_W-1:0]            rdData_ff;
	sas_afe_t                     afe_ff;
	logic [NUM_CHANNELS-1:0][7:0] level;
	int                           fails, n_checks;
	// channel code beside the expected result
	logic [11:0]                  rows [5] = '{12'h000, 12'h333, 12'h773, 12'hbff, 12'hcff};
	sas_adc_sequencer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .rdData_ff(rdData_ff),
		.waitMode(waitMode), .haltMode(haltMode), .cmpHigh(cmpHigh), .afe_ff(afe_ff), .irq_ff(irq_ff));
	sas_afe_model u_afe (.ref_clk(ref_clk), .afe_ff(afe_ff), .level(level), .cmpHigh(cmpHigh));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		busReq <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		busReq <= '0;
		#1 check(rdData_ff, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = !ref_clk;
	end
	initial begin
		#40000;
		fails++;
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		busReq = '0;
		waitMode = 1'b0;
		haltMode = 1'b0;
		fails = 0;
		n_checks = 0;
		for (int i = 0; i < NUM_CHANNELS; i++) level[i] = 8'(i * 16 + 3);
		level[0] = 8'h00;
		level[11] = 8'hff;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(RESULT_INDEX, RESULT_RESET);
		rd(CTRL_INDEX, CTRL_RESET);
		$display("test reset done");
		// wait mode must not disturb the conversions
		@(posedge ref_clk);
		waitMode <= 1'b1;
		foreach (rows[i]) begin
			wr(CTRL_INDEX, {4'h2, rows[i][11:8]});
			repeat (75) @(posedge ref_clk);
			rd(CTRL_INDEX, {4'ha, rows[i][11:8]});
			rd(RESULT_INDEX, rows[i][7:0]);
			rd(CTRL_INDEX, {4'h2, rows[i][11:8]});
		end
		@(posedge ref_clk);
		waitMode <= 1'b0;
		$display("test channel table done");
		level[11] = 8'h44;
		rd(RESULT_INDEX, 8'hff);
		repeat (100) @(posedge ref_clk);
		rd(RESULT_INDEX, 8'h44);
		$display("test continuous done");
		wr(CTRL_INDEX, 8'h2b);
		rd(CTRL_INDEX, 8'h2b);
		repeat (35) @(posedge ref_clk);
		rd(CTRL_INDEX, 8'h2b);
		repeat (15) @(posedge ref_clk);
		rd(CTRL_INDEX, 8'hab);
		$display("test abort done");
		wr(IRQ_MASK_INDEX, 8'h01);
		repeat (3) @(posedge ref_clk);
		#1 check({7'h00, irq_ff}, 8'h01);
		wr(CTRL_INDEX, 8'h0b);
		rd(IRQ_STAT_INDEX, 8'h03);
		rd(IRQ_STAT_INDEX, 8'h00);
		check({7'h00, irq_ff}, 8'h00);
		$display("test interrupt done");
		repeat (100) @(posedge ref_clk);
		rd(CTRL_INDEX, 8'h0b);
		rd(8'h3c, 8'h00);
		wr(RESULT_INDEX, 8'h5a);
		rd(RESULT_INDEX, 8'h44);
		$display("test off and refusals done");
		@(posedge ref_clk);
		haltMode <= 1'b1;
		wr(CTRL_INDEX, 8'h20);
		repeat (100) @(posedge ref_clk);
		rd(RESULT_INDEX, 8'h44);
		@(posedge ref_clk);
		haltMode <= 1'b0;
		repeat (100) @(posedge ref_clk);
		rd(RESULT_INDEX, 8'h00);
		$display("test halt done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
